/* File: logic/dag_top.v */
`default_nettype none
module dag_top (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        wrEn,
  input  wire [3:0]  wrIdx,
  input  wire [15:0] wrData,
  input  wire        opValid,
  input  wire [2:0]  opClass,
  input  wire        isByte,
  input  wire [2:0]  srcMode,
  input  wire [3:0]  srcReg,
  input  wire [2:0]  dstMode,
  input  wire [3:0]  dstReg,
  input  wire [3:0]  offsetRegField,
  input  wire [15:0] literal,
  input  wire        litUse,
  input  wire [1:0]  litSize,
  input  wire        useDirect,
  input  wire [15:0] directAddr,
  input  wire        dstToWreg,
  input  wire        progSpace,
  input  wire        bitRevEn,
  input  wire [15:0] bitRevMod,
  input  wire        xSel,
  input  wire [1:0]  xDspMode,
  input  wire [1:0]  xPostAmt,
  input  wire        ySel,
  input  wire [1:0]  yDspMode,
  input  wire [1:0]  yPostAmt,
  input  wire [15:0] xMemData,
  input  wire [15:0] yMemData,
  output reg  [15:0] xrEa,
  output reg         xrStrobe,
  output reg  [15:0] xwEa,
  output reg         xwStrobe,
  output reg  [15:0] yrEa,
  output reg         yrStrobe,
  output reg         wregDest,
  output reg  [15:0] xrData,
  output reg         xrDataValid,
  output reg  [15:0] yrData,
  output reg         yrDataValid,
  output reg  [15:0] litOut,
  output reg         litValid,
  output reg         addrErrTrap,
  output reg         modeErr
);
  `include "dag_defines.vh"

  // Working registers, indexed storage
  reg  [15:0] default_working_register [0:15];
  reg         xrInSpace;
  reg         yrInSpace;

  // Address generator wiring
  reg  [15:0] xrPtr;
  reg  [15:0] xrOff;
  reg  [2:0]  xrMode;
  reg  [2:0]  xrStep;
  reg  [3:0]  xrPtrIdx;
  reg  [15:0] yPtr;
  reg  [15:0] yOff;
  reg  [2:0]  yMode;
  reg  [2:0]  yStep;
  reg  [3:0]  yPtrIdx;
  reg  [2:0]  xwMode;
  wire [15:0] xrCalc;
  wire [15:0] xrNextPtr;
  wire        xrPtrWrite;
  wire        xrMem;
  wire [15:0] xwCalc;
  wire [15:0] xwNextPtr;
  wire        xwPtrWrite;
  wire        xwMem;
  wire [15:0] yCalc;
  wire [15:0] yNextPtr;
  wire        yPtrWrite;
  wire        yMem;

  // Decoded next values
  reg  [15:0] next_xrEa;
  reg         next_xrGo;
  reg  [15:0] next_xwEa;
  reg         next_xwGo;
  reg         next_yGo;
  reg         next_wregDest;
  reg         next_modeErr;
  reg         next_alignErr;
  reg  [15:0] next_xwPtr;
  reg  [15:0] next_litOut;
  reg         next_litErr;
  reg         isDsp;
  reg         xOk;
  reg         yOk;
  reg         commit;
  integer     i;

  // Step for increment and decrement forms
  function [2:0] stepOf;
    input byteOp;
    begin
      stepOf = byteOp ? `DAG_STEP_BYTE : `DAG_STEP_WORD;
    end
  endfunction

  // Reverse the bit order of a word
  function [15:0] revBits;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        revBits[k] = v[15 - k];
      end
    end
  endfunction

  // Reverse-carry add used by bit-reversed stepping
  function [15:0] revAdd;
    input [15:0] a;
    input [15:0] b;
    begin
      revAdd = revBits(revBits(a) + revBits(b));
    end
  endfunction

  // True when a byte address lies in the Y window
  function inYSpace;
    input [15:0] a;
    begin
      inYSpace = (a >= `DAG_Y_START) && (a <= `DAG_Y_END);
    end
  endfunction

  // Word accesses must land on an even byte address
  function misaligned;
    input [15:0] a;
    input        byteOp;
    begin
      misaligned = !byteOp && a[0];
    end
  endfunction

  // Map a DSP mode to a generic mode; bad codes give direct
  function [2:0] dspMode;
    input [1:0] m;
    begin
      case (m)
        `DAG_D_INDIR: dspMode = `DAG_M_INDIR;
        `DAG_D_POST:  dspMode = `DAG_M_POSTINC;
        `DAG_D_INDEX: dspMode = `DAG_M_REGOFF;
        default:      dspMode = `DAG_M_DIRECT;
      endcase
    end
  endfunction

  // Operand selection for the X read and Y read paths
  always @* begin
    isDsp    = (opClass == `DAG_C_DSP);
    xrPtrIdx = srcReg;
    xrMode   = srcMode;
    xrStep   = stepOf(isByte);
    yPtrIdx  = `DAG_Y_PTR_BASE + {3'b000, ySel};
    yMode    = `DAG_M_DIRECT;
    yStep    = `DAG_STEP_WORD;
    xwMode   = dstMode;
    if (isDsp) begin
      xrPtrIdx = `DAG_X_PTR_BASE + {3'b000, xSel};
      xrMode   = dspMode(xDspMode);
      xrStep   = {xPostAmt, 1'b0};
      yMode    = dspMode(yDspMode);
      yStep    = {yPostAmt, 1'b0};
    end
    if ((opClass == `DAG_C_FILE) || (opClass == `DAG_C_BRANCH) ||
        (opClass == `DAG_C_INTERRUPT_DISABLE_INSTRUCTION)) begin
      xwMode = `DAG_M_DIRECT;
    end
    xrPtr = default_working_register[xrPtrIdx];
    xrOff = default_working_register[offsetRegField];
    yPtr  = default_working_register[yPtrIdx];
    yOff  = default_working_register[offsetRegField];
  end

  // X read generator
  dag_ea_unit u_xr (
    .ptr       (xrPtr),
    .offset    (xrOff),
    .lit       (literal),
    .mode      (xrMode),
    .step      (xrStep),
    .ea        (xrCalc),
    .nextPtr   (xrNextPtr),
    .ptrWrite  (xrPtrWrite),
    .memAccess (xrMem)
  );

  // X write generator, shares the offset field with the read side
  dag_ea_unit u_xw (
    .ptr       (default_working_register[dstReg]),
    .offset    (xrOff),
    .lit       (literal),
    .mode      (xwMode),
    .step      (stepOf(isByte)),
    .ea        (xwCalc),
    .nextPtr   (xwNextPtr),
    .ptrWrite  (xwPtrWrite),
    .memAccess (xwMem)
  );

  // Y read generator, word reads only
  dag_ea_unit u_y (
    .ptr       (yPtr),
    .offset    (yOff),
    .lit       (16'h0000),
    .mode      (yMode),
    .step      (yStep),
    .ea        (yCalc),
    .nextPtr   (yNextPtr),
    .ptrWrite  (yPtrWrite),
    .memAccess (yMem)
  );

  // Class checks, direct addresses and the alignment trap
  always @* begin
    next_xrEa     = xrCalc;
    next_xrGo     = xrMem;
    next_xwEa     = xwCalc;
    next_xwGo     = xwMem;
    next_yGo      = 1'b0;
    next_wregDest = 1'b0;
    next_modeErr  = 1'b0;
    next_xwPtr    = xwNextPtr;
    xOk           = 1'b1;
    yOk           = 1'b1;
    case (opClass)
      `DAG_C_FILE: begin
        // Direct field is zero-extended, so only the low window is reached
        next_xrEa = {3'b000, directAddr[`DAG_FILE_BITS-1:0]};
        next_xrGo = useDirect;
        next_xwEa = next_xrEa;
        next_xwGo = useDirect && !dstToWreg;
        next_wregDest = dstToWreg;
      end
      `DAG_C_MCU: begin
        // Offset forms belong to move and accumulator only
        if ((srcMode == `DAG_M_REGOFF) || (srcMode == `DAG_M_LITOFF) ||
            (dstMode == `DAG_M_REGOFF) || (dstMode == `DAG_M_LITOFF)) begin
          next_modeErr = 1'b1;
        end
      end
      `DAG_C_MOVE: begin
        if (useDirect) begin
          next_xrEa = directAddr;
          next_xrGo = 1'b1;
        end
      end
      `DAG_C_DSP: begin
        next_yGo = yMem;
        if ((yDspMode == 2'd3) || (xDspMode == 2'd3)) begin
          next_modeErr = 1'b1;
        end
        if (((xDspMode == `DAG_D_INDEX) && !xSel) ||
            ((yDspMode == `DAG_D_INDEX) && !ySel)) begin
          next_modeErr = 1'b1;
        end
        if (((xDspMode == `DAG_D_POST) && (xPostAmt == 2'd0)) ||
            ((yDspMode == `DAG_D_POST) && (yPostAmt == 2'd0))) begin
          next_modeErr = 1'b1;
        end
        xOk = !inYSpace(xrCalc);
        yOk = inYSpace(yCalc);
      end
      default: begin
        next_xrGo = 1'b0;
        next_xwGo = 1'b0;
      end
    endcase
    // Bit-reversed stepping replaces the linear post-increment of the X write pointer, outside program space only
    if (bitRevEn && !progSpace && (xwMode == `DAG_M_POSTINC)) begin
      next_xwPtr = revAdd(default_working_register[dstReg], bitRevMod);
    end
    next_alignErr = (next_xrGo && misaligned(next_xrEa, isByte && !isDsp)) ||
                    (next_xwGo && misaligned(next_xwEa, isByte)) ||
                    (next_yGo && misaligned(yCalc, 1'b0));
    // A literal width fault refuses the operation just like a mode fault
    commit = opValid && !next_modeErr && !(litUse && next_litErr) &&
             !next_alignErr;
  end

  // Literal forming and width legality per class
  always @* begin
    next_litOut = literal;
    next_litErr = 1'b0;
    case (litSize)
      `DAG_L_5:  next_litOut = {11'h000, literal[4:0]};
      `DAG_L_10: next_litOut = {6'h00, literal[9:0]};
      `DAG_L_8:  next_litOut = {8'h00, literal[7:0]};
      default:   next_litOut = literal;
    endcase
    case (opClass)
      `DAG_C_MCU: begin
        next_litErr = (litSize != `DAG_L_5) && (litSize != `DAG_L_10);
      end
      `DAG_C_MOVE: begin
        next_litErr = 1'b0;
      end
      `DAG_C_BRANCH: begin
        next_litOut = literal;
      end
      `DAG_C_INTERRUPT_DISABLE_INSTRUCTION: begin
        next_litOut = {2'b00, literal[`DAG_INTERRUPT_DISABLE_INSTRUCTION_BITS-1:0]};
      end
      default: begin
        next_litErr = 1'b1;
      end
    endcase
  end

  // Working registers: core writes first, modifications override
  always @(posedge clk_sys) begin
    if (srst) begin
      for (i = 0; i < 16; i = i + 1) begin
        default_working_register[i] <= `DAG_RST_WORD;
      end
    end else begin
      if (wrEn) begin
        default_working_register[wrIdx] <= wrData;
      end
      if (commit && xrPtrWrite && next_xrGo && (opClass != `DAG_C_FILE)) begin
        default_working_register[xrPtrIdx] <= xrNextPtr;
      end
      if (commit && isDsp && yPtrWrite) begin
        default_working_register[yPtrIdx] <= yNextPtr;
      end
      if (commit && xwPtrWrite) begin
        default_working_register[dstReg] <= next_xwPtr;
      end
    end
  end

  // Address strobes, traps and literal result
  always @(posedge clk_sys) begin
    if (srst) begin
      xrEa        <= `DAG_RST_WORD;
      xrStrobe    <= 1'b0;
      xwEa        <= `DAG_RST_WORD;
      xwStrobe    <= 1'b0;
      yrEa        <= `DAG_RST_WORD;
      yrStrobe    <= 1'b0;
      wregDest    <= 1'b0;
      xrInSpace   <= 1'b1;
      yrInSpace   <= 1'b1;
      litOut      <= `DAG_RST_WORD;
      litValid    <= 1'b0;
      addrErrTrap <= 1'b0;
      modeErr     <= 1'b0;
    end else begin
      xrStrobe    <= commit && next_xrGo;
      xwStrobe    <= commit && next_xwGo;
      yrStrobe    <= commit && next_yGo;
      wregDest    <= commit && next_wregDest;
      addrErrTrap <= opValid && !next_modeErr && !(litUse && next_litErr) &&
                     next_alignErr;
      modeErr     <= opValid && (next_modeErr || (litUse && next_litErr));
      litValid    <= opValid && litUse && !next_litErr;
      if (opValid) begin
        xrEa      <= next_xrEa;
        xwEa      <= next_xwEa;
        yrEa      <= yCalc;
        xrInSpace <= xOk;
        yrInSpace <= yOk;
        litOut    <= next_litOut;
      end
    end
  end

  // Read data one cycle after the strobe; out-of-space reads give zero
  always @(posedge clk_sys) begin
    if (srst) begin
      xrData      <= `DAG_BUS_DEFAULT;
      xrDataValid <= 1'b0;
      yrData      <= `DAG_BUS_DEFAULT;
      yrDataValid <= 1'b0;
    end else begin
      xrDataValid <= xrStrobe;
      yrDataValid <= yrStrobe;
      xrData <= (xrStrobe && xrInSpace) ? xMemData : `DAG_BUS_DEFAULT;
      yrData <= (yrStrobe && yrInSpace) ? yMemData : `DAG_BUS_DEFAULT;
    end
  end
endmodule
`default_nettype wire

/* File: logic/dag_defines.vh */
`ifndef DAG_DEFINES_VH
`define DAG_DEFINES_VH

// Addressing mode codes
`define DAG_M_DIRECT   3'd0
`define DAG_M_INDIR    3'd1
`define DAG_M_POSTINC  3'd2
`define DAG_M_POSTDEC  3'd3
`define DAG_M_PREINC   3'd4
`define DAG_M_PREDEC   3'd5
`define DAG_M_REGOFF   3'd6
`define DAG_M_LITOFF   3'd7

// Instruction class codes
`define DAG_C_FILE     3'd0
`define DAG_C_MCU      3'd1
`define DAG_C_MOVE     3'd2
`define DAG_C_DSP      3'd3
`define DAG_C_BRANCH   3'd4
`define DAG_C_INTERRUPT_DISABLE_INSTRUCTION     3'd5

// Dual-operand DSP mode codes
`define DAG_D_INDIR    2'd0
`define DAG_D_POST     2'd1
`define DAG_D_INDEX    2'd2

// Literal size codes
`define DAG_L_5        2'd0
`define DAG_L_10       2'd1
`define DAG_L_8        2'd2
`define DAG_L_16       2'd3

// Field widths and fixed registers
`define DAG_FILE_BITS  13
`define DAG_INTERRUPT_DISABLE_INSTRUCTION_BITS  14
`define DAG_WREG0      4'h0
`define DAG_X_PTR_BASE 4'h8
`define DAG_Y_PTR_BASE 4'hA
`define DAG_STEP_BYTE  3'd1
`define DAG_STEP_WORD  3'd2

// Y space window in split mode (plain defaults)
`define DAG_Y_START    16'h0800
`define DAG_Y_END      16'h0FFF

// Reset values
`define DAG_RST_WORD   16'h0000
`define DAG_BUS_DEFAULT 16'h0000

`endif

/* File: logic/dag_ea_unit.v */
`default_nettype none
module dag_ea_unit (
  input  wire [15:0] ptr,
  input  wire [15:0] offset,
  input  wire [15:0] lit,
  input  wire [2:0]  mode,
  input  wire [2:0]  step,
  output reg  [15:0] ea,
  output reg  [15:0] nextPtr,
  output reg         ptrWrite,
  output reg         memAccess
);
  `include "dag_defines.vh"

  wire [15:0] stepExt;

  assign stepExt = {13'h0000, step};

  // One effective address plus the pointer write-back it implies
  always @* begin
    ea        = ptr;
    nextPtr   = ptr;
    ptrWrite  = 1'b0;
    memAccess = 1'b1;
    case (mode)
      `DAG_M_DIRECT: begin
        memAccess = 1'b0;
      end
      `DAG_M_INDIR: begin
        ea = ptr;
      end
      `DAG_M_POSTINC: begin
        nextPtr  = ptr + stepExt;
        ptrWrite = 1'b1;
      end
      `DAG_M_POSTDEC: begin
        nextPtr  = ptr - stepExt;
        ptrWrite = 1'b1;
      end
      `DAG_M_PREINC: begin
        ea       = ptr + stepExt;
        nextPtr  = ptr + stepExt;
        ptrWrite = 1'b1;
      end
      `DAG_M_PREDEC: begin
        ea       = ptr - stepExt;
        nextPtr  = ptr - stepExt;
        ptrWrite = 1'b1;
      end
      `DAG_M_REGOFF: begin
        ea = ptr + offset;
      end
      `DAG_M_LITOFF: begin
        ea = ptr + lit;
      end
      default: begin
        memAccess = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: verification/dag_mem_model.sv */
`default_nettype none
module dag_mem_model (
  input  wire logic [15:0] xrEa,
  input  wire logic        xrStrobe,
  input  wire logic [15:0] yrEa,
  input  wire logic        yrStrobe,
  output logic      [15:0] xMemData,
  output logic      [15:0] yMemData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each word is a scramble of its address; an idle bus shows the inverse,
  // so data taken outside the strobe cycle cannot match
  assign xMemData = xrStrobe ? xrEa ^ 16'hA5A5 : ~(xrEa ^ 16'hA5A5);
  assign yMemData = yrStrobe ? yrEa ^ 16'h5A5A : ~(yrEa ^ 16'h5A5A);
endmodule
`default_nettype wire

/* File: verification/dag_chk.sv */
`include "dag_defines.vh"
`default_nettype none
module dag_chk (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        opValid,
  input wire logic [2:0]  opClass,
  input wire logic        isByte,
  input wire logic [15:0] xrEa,
  input wire logic        xrStrobe,
  input wire logic        xwStrobe,
  input wire logic [15:0] yrEa,
  input wire logic        yrStrobe,
  input wire logic [15:0] xrData,
  input wire logic        xrDataValid,
  input wire logic [15:0] yrData,
  input wire logic        yrDataValid,
  input wire logic        addrErrTrap,
  input wire logic        modeErr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // A refused operation must not touch memory
  a_trap_quiet: assert property (
    addrErrTrap |-> !(xrStrobe || xwStrobe || yrStrobe))
    else $error("access despite address trap");
  a_merr_quiet: assert property (
    modeErr |-> !addrErrTrap && !(xrStrobe || xwStrobe || yrStrobe))
    else $error("access despite mode fault");
  // Y path only opens for the dual-operand class, with X alongside
  a_y_class: assert property (
    yrStrobe |-> $past(opValid) && $past(opClass) == `DAG_C_DSP && xrStrobe)
    else $error("Y read outside dual-operand op");
  a_read_data: assert property (
    xrStrobe |=> xrDataValid && (yrDataValid == $past(yrStrobe)))
    else $error("read data not one cycle after strobe");
  // Past values: the address may move on in the data cycle
  a_y_default: assert property (
    yrDataValid && ($past(yrEa) < `DAG_Y_START || $past(yrEa) > `DAG_Y_END)
    |-> yrData == `DAG_BUS_DEFAULT)
    else $error("Y data outside Y space not zero");
  a_x_default: assert property (
    xrDataValid && $past(yrStrobe) && $past(xrEa) >= `DAG_Y_START &&
    $past(xrEa) <= `DAG_Y_END |-> xrData == `DAG_BUS_DEFAULT)
    else $error("X data inside Y space not zero");
  a_file_reach: assert property (
    xrStrobe && $past(opValid) && $past(opClass) == `DAG_C_FILE
    |-> xrEa < 16'h2000)
    else $error("file address beyond window");
  a_even_word: assert property (
    xrStrobe && !$past(isByte) |-> !xrEa[0])
    else $error("odd word address issued");
  c_dsp: cover property (yrStrobe && xrStrobe);
  c_trap: cover property (addrErrTrap);
  c_merr: cover property (modeErr);
endmodule
bind dag_top dag_chk u_chk (.clk_sys, .srst, .opValid, .opClass, .isByte,
  .xrEa, .xrStrobe, .xwStrobe, .yrEa, .yrStrobe, .xrData, .xrDataValid,
  .yrData, .yrDataValid, .addrErrTrap, .modeErr);
`default_nettype wire

/* File: verification/dag_top_tb.sv */
`include "dag_defines.vh"
`default_nettype none
module dag_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, srst, wrEn, opValid, isByte, litUse, useDirect;
  logic        dstToWreg, progSpace, bitRevEn, xSel, ySel;
  logic        xrStrobe, xwStrobe, yrStrobe, wregDest, xrDataValid;
  logic        yrDataValid, litValid, addrErrTrap, modeErr;
  logic [1:0]  litSize, xDspMode, xPostAmt, yDspMode, yPostAmt;
  logic [2:0]  opClass, srcMode, dstMode;
  logic [3:0]  wrIdx, srcReg, dstReg, offsetRegField;
  logic [15:0] wrData, literal, directAddr, bitRevMod, xMemData, yMemData;
  logic [15:0] xrEa, xwEa, yrEa, xrData, yrData, litOut, p, s, ea;
  logic [15:0] w [16];
  logic [15:0] lm [6] = '{16'h001F, 16'h03FF, 16'h00FF, 16'hFFFF,
                          16'hFFFF, 16'h3FFF};
  int          lc [6] = '{1, 1, 2, 2, 4, 5};
  int          ls [6] = '{0, 1, 2, 3, 3, 3};
  logic [19:0] q [$];
  int          n_fail, cmp_count, m, b, a, i;

  dag_top DUT (.clk_sys, .srst, .wrEn, .wrIdx, .wrData, .opValid, .opClass,
    .isByte, .srcMode, .srcReg, .dstMode, .dstReg, .offsetRegField,
    .literal, .litUse, .litSize, .useDirect, .directAddr, .dstToWreg,
    .progSpace, .bitRevEn, .bitRevMod, .xSel, .xDspMode, .xPostAmt, .ySel,
    .yDspMode, .yPostAmt, .xMemData, .yMemData, .xrEa, .xrStrobe, .xwEa,
    .xwStrobe, .yrEa, .yrStrobe, .wregDest, .xrData, .xrDataValid, .yrData,
    .yrDataValid, .litOut, .litValid, .addrErrTrap, .modeErr);
  dag_mem_model MEM (.xrEa, .xrStrobe, .yrEa, .yrStrobe, .xMemData,
    .yMemData);

  always #4 clk_sys = ~clk_sys;

  task automatic chk(input logic [19:0] seen, input logic [19:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // An output with no note waiting is always a mismatch
  task automatic take(input logic [19:0] seen);
    if (q.size() == 0)
      chk(seen, ~seen);
    else
      chk(seen, q.pop_front());
  endtask
  task automatic exp(input logic [3:0] k, input logic [15:0] v);
    q.push_back({k, v});
  endtask
  task automatic wr(input logic [3:0] k, input logic [15:0] v);
    wrEn = 1'b1;
    wrIdx = k;
    wrData = v;
    @(negedge clk_sys);
    wrEn = 1'b0;
    w[k] = v;
    // Let an edge pass so a following write never re-raises in one step
    @(negedge clk_sys);
  endtask
  // Ops are spaced so the data cycle of one never meets the next strobe
  task automatic go;
    opValid = 1'b1;
    @(negedge clk_sys);
    opValid = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Outputs settle by the falling edge; fixed order matches the notes
  always @(negedge clk_sys) begin
    if (srst === 1'b0) begin
      if (xrStrobe === 1'b1) take({4'h1, xrEa});
      if (xwStrobe === 1'b1) take({4'h2, xwEa});
      if (yrStrobe === 1'b1) take({4'h3, yrEa});
      if (wregDest === 1'b1) take({4'h4, 16'h0000});
      if (xrDataValid === 1'b1) take({4'h5, xrData});
      if (yrDataValid === 1'b1) take({4'h6, yrData});
      if (litValid === 1'b1) take({4'h7, litOut});
      if (addrErrTrap === 1'b1) take({4'h8, 16'h0000});
      if (modeErr === 1'b1) take({4'h9, 16'h0000});
    end
  end

  initial begin
    #200000;
    n_fail++;
    test_done;
  end

  initial begin
    {clk_sys, wrEn, opValid, isByte, litUse, useDirect, dstToWreg} = '0;
    {progSpace, bitRevEn, xSel, ySel, litSize, xDspMode, xPostAmt} = '0;
    {yDspMode, yPostAmt, opClass, srcMode, dstMode, wrIdx, srcReg} = '0;
    {dstReg, offsetRegField, wrData, literal, directAddr, bitRevMod} = '0;
    srst = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(9));
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    chk({xrStrobe, xwStrobe, yrStrobe, litValid, xrEa}, '0);
    // Every pointer form of the move class, word pass then byte pass
    opClass = `DAG_C_MOVE;
    dstMode = `DAG_M_INDIR;
    srcReg = 4'd2;
    dstReg = 4'd3;
    offsetRegField = 4'd5;
    literal = 16'h0006;
    wr(4'd3, 16'h4000);
    wr(4'd5, 16'h0010);
    for (b = 0; b < 2; b++) begin
      isByte = b[0];
      s = b ? 16'h0001 : 16'h0002;
      wr(4'd2, 16'h3000 | 16'($urandom & 32'h0FFE));
      for (m = 1; m < 8; m++) begin
        p = w[2];
        srcMode = m[2:0];
        ea = m == 4 ? p + s : m == 5 ? p - s : m == 6 ? p + w[5] :
             m == 7 ? p + literal : p;
        exp(4'h1, ea);
        exp(4'h2, w[3]);
        exp(4'h5, ea ^ 16'hA5A5);
        go;
        w[2] = (m == 2 || m == 4) ? p + s : (m == 3 || m == 5) ? p - s : p;
      end
    end
    $display("move address forms done");
    // Odd word access, then an offset form the MCU class refuses
    isByte = 1'b0;
    srcMode = `DAG_M_INDIR;
    wr(4'd2, 16'h3001);
    exp(4'h8, 16'h0000);
    go;
    opClass = `DAG_C_MCU;
    srcMode = `DAG_M_REGOFF;
    exp(4'h9, 16'h0000);
    go;
    $display("refusals done");
    // Literal widths of every class that carries one
    srcMode = `DAG_M_DIRECT;
    dstMode = `DAG_M_DIRECT;
    litUse = 1'b1;
    for (i = 0; i < 6; i++) begin
      opClass = lc[i][2:0];
      litSize = ls[i][1:0];
      literal = 16'($urandom);
      exp(4'h7, literal & lm[i]);
      go;
    end
    opClass = `DAG_C_MCU;
    litSize = `DAG_L_8;
    exp(4'h9, 16'h0000);
    go;
    litUse = 1'b0;
    $display("literals done");
    // Dual-operand reads with post steps 2, 4 and 6, then split faults
    opClass = `DAG_C_DSP;
    xDspMode = `DAG_D_POST;
    yDspMode = `DAG_D_INDIR;
    wr(4'd8, 16'h0100);
    wr(4'd10, 16'h0900);
    for (a = 1; a < 4; a++) begin
      xPostAmt = a[1:0];
      exp(4'h1, w[8]);
      exp(4'h3, w[10]);
      exp(4'h5, w[8] ^ 16'hA5A5);
      exp(4'h6, w[10] ^ 16'h5A5A);
      go;
      w[8] = w[8] + 16'(2 * a);
    end
    wr(4'd8, 16'h0A00);
    wr(4'd10, 16'h2000);
    exp(4'h1, 16'h0A00);
    exp(4'h3, 16'h2000);
    exp(4'h5, 16'h0000);
    exp(4'h6, 16'h0000);
    go;
    for (a = 2; a < 4; a++) begin
      xDspMode = a[1:0];
      exp(4'h9, 16'h0000);
      go;
    end
    // Indexed reads through the second pointer of each side
    xSel = 1'b1;
    ySel = 1'b1;
    xDspMode = `DAG_D_INDEX;
    yDspMode = `DAG_D_INDEX;
    wr(4'd9, 16'h0200);
    wr(4'd11, 16'h0A00);
    exp(4'h1, 16'h0210);
    exp(4'h3, 16'h0A10);
    exp(4'h5, 16'h0210 ^ 16'hA5A5);
    exp(4'h6, 16'h0A10 ^ 16'h5A5A);
    go;
    $display("dual-operand done");
    // Reverse carry on the X write pointer, then linear in program space
    opClass = `DAG_C_MOVE;
    dstMode = `DAG_M_POSTINC;
    bitRevEn = 1'b1;
    bitRevMod = 16'h0008;
    wr(4'd3, 16'h4008);
    exp(4'h2, 16'h4008);
    go;
    progSpace = 1'b1;
    exp(4'h2, 16'h4004);
    go;
    dstMode = `DAG_M_INDIR;
    exp(4'h2, 16'h4006);
    go;
    {progSpace, bitRevEn} = '0;
    $display("bit-reversed stepping done");
    // File register with the working register as target
    opClass = `DAG_C_FILE;
    useDirect = 1'b1;
    dstToWreg = 1'b1;
    directAddr = 16'($urandom & 32'hFFFE);
    ea = directAddr & 16'h1FFF;
    exp(4'h1, ea);
    exp(4'h4, 16'h0000);
    exp(4'h5, ea ^ 16'hA5A5);
    go;
    $display("file register done");
    for (i = 0; i < 20 && q.size() > 0; i++) @(negedge clk_sys);
    if (q.size() > 0) n_fail++;
    test_done;
  end
endmodule
`default_nettype wire
